// ### rtl/hmc_chan.v
// Purpose: state and error latch of one heating channel
// Assumes: inputs synchronous to clk
// Notes: error monitoring only runs while the channel is activated
`timescale 1ns/1ps
`default_nettype none
`include "hmc_defs.vh"

module hmc_chan (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire act,
  input wire run_allowed,
  // power stage feedback
  input wire power_ok,
  input wire warmup,
  input wire fuse_ok,
  input wire [`HMC_CAUSE_W-1:0] cause,
  // results
  output reg enable,
  output reg [`HMC_WORD_W-1:0] state_word
);

  reg err;
  reg [`HMC_CAUSE_W-1:0] err_cause;
  wire fault;
  wire next_enable;

  // monitoring is tied to act, so it restarts cleanly on every re-activation
  assign fault = act && (cause != {`HMC_CAUSE_W{1'b0}});
  assign next_enable = act && run_allowed && !err && !fault;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      err <= 1'b0;
      err_cause <= {`HMC_CAUSE_W{1'b0}};
    end else if (fault) begin
      // set wins over clear
      err <= 1'b1;
      err_cause <= cause;
    end else if (!act) begin
      // held until the channel bit drops, whatever the master flag does
      err <= 1'b0;
      err_cause <= {`HMC_CAUSE_W{1'b0}};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= 1'b0;
      state_word <= `HMC_RST_WORD;
    end else begin
      enable <= next_enable;
      state_word <= `HMC_RST_WORD;
      state_word[`HMC_CS_ON] <= next_enable && (power_ok || warmup);
      state_word[`HMC_CS_WARMUP] <= next_enable && warmup;
      state_word[`HMC_CS_ERROR] <= (err || fault) && act;
      state_word[`HMC_CS_FUSE_OK] <= fuse_ok;
      // a dropped channel shows no stale cause while its latch empties
      state_word[`HMC_CS_CAUSE_MSB:`HMC_CS_CAUSE_LSB] <= act ? (fault ? cause : err_cause) :
        {`HMC_CAUSE_W{1'b0}};
    end
  end

endmodule
`default_nettype wire

// ### rtl/hmc_defs.vh
// Purpose: constants of the heater module channel state block
// Assumes: 50 MHz system clock, nine heating channels
// Notes: bit positions refer to the control, module state and channel state words
`ifndef HMC_DEFS_VH
`define HMC_DEFS_VH

// clock and timing
`define HMC_CLK_KHZ 50000
`define HMC_PHASE_TOL_MS 2000
// 2000 ms at 50000 cycles per ms, sized to the counter so nothing is cut silently
`define HMC_PHASE_TOL_CYC 27'd100000000
`define HMC_PHASE_CNT_W 27

// geometry
`define HMC_NUM_CH 9
`define HMC_NUM_PH 3
`define HMC_WORD_W 16
`define HMC_CAUSE_W 5

// control word fields
`define HMC_CW_CH_LSB 0
`define HMC_CW_MASTER_ON 14
`define HMC_CW_ERR_RESET 15

// module state word fields
`define HMC_MS_READY_ON 0
`define HMC_MS_READY_OP 1
`define HMC_MS_ERROR 2
`define HMC_MS_STATE_LSB 4
`define HMC_MS_STATE_MSB 5

// channel state word fields
`define HMC_CS_ON 0
`define HMC_CS_WARMUP 1
`define HMC_CS_ERROR 2
`define HMC_CS_FUSE_OK 3
`define HMC_CS_CAUSE_LSB 8
`define HMC_CS_CAUSE_MSB 12

// module error codes
`define HMC_EC_NONE 4'h0
`define HMC_EC_PARAM 4'h1
`define HMC_EC_SUPPLY 4'h2
`define HMC_EC_WDOG 4'h3
`define HMC_EC_CHANNEL 4'h4
`define HMC_EC_FAN 4'h5
`define HMC_EC_TEMP 4'h6
`define HMC_EC_PHASE 4'h7
`define HMC_EC_FREQ 4'h8

// reset values
`define HMC_RST_WORD 16'h0000
`define HMC_RST_CODE 4'h0

`endif

// ### rtl/hmc_heater_state.v
// Purpose: module and channel state logic of a nine channel heater controller
// Assumes: all inputs synchronous to SYS_CLK; control word held by the fieldbus side
// Notes: status words are re-registered every clock and need no request
// Notes: module error reset is level sensitive on the reset bit
// Notes: channel error reset is the drop of the channel bit
//
// What this block does
// - module state word sent continuously, unrequested
// - ready-on needs 24V, mains and frequency
// - ready-operate is ready-on plus master on
// - module error: flag, code, all channels off
// - bit 15 clears error once cause gone
// - after reset return to ready-on, outputs stay off
// - outputs resume only on master-on rising edge
// - report state of every activated channel
// - channel on while activated and powered
// - warm-up flag while phase-angle warm-up runs
// - channel error sets flag, switches channel off
// - state bits 8 to 12 hold cause
// - channel control bit resets channel error
// - monitoring restarts on channel re-activation
// - master off: errors held until bit cleared
// - channel errors only for activated channels
// - channel word shows output fuse condition
// - nine independent channels with own state
// - phase out of tolerance over 2 s
// - fuse, switch, load faults need no master
`timescale 1ns/1ps
`default_nettype none
`include "hmc_defs.vh"

module hmc_heater_state #(
  parameter [`HMC_PHASE_CNT_W-1:0] PHASE_TOL_CYCLES = `HMC_PHASE_TOL_CYC
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RESET,
  // control word from the fieldbus master
  input wire [`HMC_WORD_W-1:0] CTRL_WORD,
  // supply monitors
  input wire SUPPLY_24V_OK,
  input wire MAINS_OK,
  input wire FREQ_DETECTED,
  input wire FREQ_OUT_OF_RANGE,
  input wire [`HMC_NUM_PH-1:0] PHASE_IN_TOL,
  // other module error causes
  input wire PARAM_INVALID,
  input wire WATCHDOG_EXPIRED,
  input wire FAN_FAILED,
  input wire HEATSINK_OVERTEMP,
  // per channel feedback from the power stage
  input wire [`HMC_NUM_CH-1:0] CH_POWER_OK,
  input wire [`HMC_NUM_CH-1:0] CH_WARMUP,
  input wire [`HMC_NUM_CH-1:0] CH_FUSE_OK,
  input wire [`HMC_NUM_CH*`HMC_CAUSE_W-1:0] CH_CAUSE,
  // status to the fieldbus master
  output reg [`HMC_WORD_W-1:0] MODULE_STATE,
  output reg [`HMC_WORD_W-1:0] MODULE_ERR_WORD,
  output wire [`HMC_NUM_CH*`HMC_WORD_W-1:0] CH_STATE,
  // channel enables to the power stage
  output wire [`HMC_NUM_CH-1:0] CH_ENABLE
);

  // module states
  localparam [1:0] ST_NOT_READY = 2'h0;
  localparam [1:0] ST_READY_ON = 2'h1;
  localparam [1:0] ST_OPERATE = 2'h2;
  localparam [1:0] ST_FAULT = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg mod_err;
  reg [3:0] err_code;
  reg [3:0] next_code;
  reg master_prev;
  reg armed;
  reg run_allowed;
  reg [`HMC_NUM_CH-1:0] ch_err_seen;

  wire master_on;
  wire master_rise;
  wire err_reset_req;
  wire supplies_good;
  wire [`HMC_NUM_PH-1:0] phase_over;
  wire cause_present;
  wire ready_on;
  wire [`HMC_NUM_CH-1:0] ch_act;
  wire next_run_allowed;

  // one flag per module error cause
  wire cause_param;
  wire cause_supply;
  wire cause_wdog;
  wire cause_fan;
  wire cause_temp;
  wire cause_phase;
  wire cause_freq;

  // status words before their output registers
  reg [`HMC_WORD_W-1:0] next_mod_state;
  reg [`HMC_WORD_W-1:0] next_err_word;
  wire [`HMC_NUM_CH-1:0] ch_err_bit;
  wire ch_err_any;

  assign master_on = CTRL_WORD[`HMC_CW_MASTER_ON];
  assign err_reset_req = CTRL_WORD[`HMC_CW_ERR_RESET];
  assign master_rise = master_on && !master_prev;
  assign ch_act = CTRL_WORD[`HMC_CW_CH_LSB+`HMC_NUM_CH-1:`HMC_CW_CH_LSB];

  // all three supply conditions together
  assign supplies_good = SUPPLY_24V_OK && MAINS_OK && FREQ_DETECTED;

  // phase tolerance timers; a short excursion is filtered, a long one is an error
  genvar p;
  generate
    for (p = 0; p < `HMC_NUM_PH; p = p + 1) begin : g_phase
      reg [`HMC_PHASE_CNT_W-1:0] cnt;
      always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
          cnt <= {`HMC_PHASE_CNT_W{1'b0}};
        end else if (PHASE_IN_TOL[p]) begin
          cnt <= {`HMC_PHASE_CNT_W{1'b0}};
        end else if (cnt != PHASE_TOL_CYCLES) begin
          cnt <= cnt + {{(`HMC_PHASE_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // saturating count; out of band for the full time counts as expired
      assign phase_over[p] = (cnt == PHASE_TOL_CYCLES);
    end
  endgenerate

  // causes listed in code priority order
  assign cause_param = PARAM_INVALID;
  assign cause_supply = !SUPPLY_24V_OK;
  assign cause_wdog = WATCHDOG_EXPIRED;
  assign cause_fan = FAN_FAILED;
  assign cause_temp = HEATSINK_OVERTEMP;
  assign cause_phase = |phase_over;
  assign cause_freq = FREQ_OUT_OF_RANGE;

  // any module error cause, phase, frequency and supply included
  assign cause_present = cause_param || cause_supply || cause_wdog || cause_fan ||
                         cause_temp || cause_phase || cause_freq;

  // ready-on also requires no latched module error
  assign ready_on = supplies_good && !mod_err;

  // lowest code wins when several causes are present at once
  always @* begin
    next_code = `HMC_EC_NONE;
    if (PARAM_INVALID) begin
      next_code = `HMC_EC_PARAM;
    end else if (!SUPPLY_24V_OK) begin
      next_code = `HMC_EC_SUPPLY;
    end else if (WATCHDOG_EXPIRED) begin
      next_code = `HMC_EC_WDOG;
    end else if (FAN_FAILED) begin
      next_code = `HMC_EC_FAN;
    end else if (HEATSINK_OVERTEMP) begin
      next_code = `HMC_EC_TEMP;
    end else if (|phase_over) begin
      next_code = `HMC_EC_PHASE;
    end else if (FREQ_OUT_OF_RANGE) begin
      next_code = `HMC_EC_FREQ;
    end
  end

  // module error flag; a present cause blocks the reset, so set wins
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      mod_err <= 1'b0;
    end else if (cause_present) begin
      mod_err <= 1'b1;
    end else if (mod_err && err_reset_req) begin
      mod_err <= 1'b0;
    end
  end

  // code of the latched error, kept for diagnosis until the reset
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      err_code <= `HMC_RST_CODE;
    end else if (cause_present) begin
      err_code <= next_code;
    end else if (mod_err && err_reset_req) begin
      err_code <= `HMC_RST_CODE;
    end
  end

  // previous master-on level; reset value matches the idle level of the bit
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      master_prev <= 1'b0;
    end else begin
      master_prev <= master_on;
    end
  end

  // outputs re-armed only by a fresh master-on edge after a module error
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      armed <= 1'b1;
    end else if (cause_present || mod_err) begin
      armed <= 1'b0;
    end else if (master_rise) begin
      armed <= 1'b1;
    end
  end

  // module state sequence
  always @* begin
    next_state = state;
    case (state)
      ST_NOT_READY: begin
        if (mod_err || cause_present) begin
          next_state = ST_FAULT;
        end else if (supplies_good) begin
          next_state = ST_READY_ON;
        end
      end
      ST_READY_ON: begin
        if (mod_err || cause_present) begin
          next_state = ST_FAULT;
        end else if (!supplies_good) begin
          next_state = ST_NOT_READY;
        end else if (master_on) begin
          next_state = ST_OPERATE;
        end
      end
      ST_OPERATE: begin
        if (mod_err || cause_present) begin
          next_state = ST_FAULT;
        end else if (!supplies_good) begin
          next_state = ST_NOT_READY;
        end else if (!master_on) begin
          next_state = ST_READY_ON;
        end
      end
      ST_FAULT: begin
        // after a reset with no cause left the module returns to ready-on, or to not-ready without supplies, outputs off
        if (!cause_present && err_reset_req) begin
          next_state = supplies_good ? ST_READY_ON : ST_NOT_READY;
        end
      end
      default: begin
        next_state = ST_NOT_READY;
      end
    endcase
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  // every channel drops two clocks after a module error cause appears
  assign next_run_allowed = armed && master_on && ready_on && !cause_present;

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      run_allowed <= 1'b0;
    end else begin
      run_allowed <= next_run_allowed;
    end
  end

  // nine channels, each with its own latch and state word
  genvar c;
  generate
    for (c = 0; c < `HMC_NUM_CH; c = c + 1) begin : g_ch
      hmc_chan u_chan (
        .clk(SYS_CLK),
        .rst(RESET),
        .act(ch_act[c]),
        .run_allowed(run_allowed),
        .power_ok(CH_POWER_OK[c]),
        .warmup(CH_WARMUP[c]),
        .fuse_ok(CH_FUSE_OK[c]),
        .cause(CH_CAUSE[c*`HMC_CAUSE_W +: `HMC_CAUSE_W]),
        .enable(CH_ENABLE[c]),
        .state_word(CH_STATE[c*`HMC_WORD_W +: `HMC_WORD_W])
      );
      assign ch_err_bit[c] = CH_STATE[c*`HMC_WORD_W + `HMC_CS_ERROR];
    end
  endgenerate

  // one process for all flags keeps a single driver on the vector
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ch_err_seen <= {`HMC_NUM_CH{1'b0}};
    end else begin
      ch_err_seen <= ch_err_bit;
    end
  end

  assign ch_err_any = |ch_err_seen;

  // module state word, built in full before it is registered
  always @* begin
    next_mod_state = `HMC_RST_WORD;
    next_mod_state[`HMC_MS_READY_ON] = ready_on && !cause_present;
    next_mod_state[`HMC_MS_READY_OP] = ready_on && !cause_present && master_on;
    next_mod_state[`HMC_MS_ERROR] = mod_err || cause_present;
    next_mod_state[`HMC_MS_STATE_MSB:`HMC_MS_STATE_LSB] = next_state;
  end

  // a live cause shows its own code before the latch has caught it
  always @* begin
    next_err_word = `HMC_RST_WORD;
    if (cause_present) begin
      next_err_word[3:0] = next_code;
    end else if (mod_err) begin
      next_err_word[3:0] = err_code;
    end else if (ch_err_any) begin
      // channel fault only, the rest of the module keeps running
      next_err_word[3:0] = `HMC_EC_CHANNEL;
    end
  end

  // status words refreshed on every clock, no poll needed
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      MODULE_STATE <= `HMC_RST_WORD;
    end else begin
      MODULE_STATE <= next_mod_state;
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      MODULE_ERR_WORD <= `HMC_RST_WORD;
    end else begin
      MODULE_ERR_WORD <= next_err_word;
    end
  end

endmodule
`default_nettype wire

// ### testbench/hmc_checker.sv
// Purpose: port assertions for the heater state block
// Assumes: channels 0 and 3 stand for all nine channels
// Notes: bound into every hmc_heater_state instance
`timescale 1ns/1ps
`default_nettype none
module hmc_checker (
  // clock and reset
  input wire SYS_CLK,
  input wire RESET,
  // inputs watched
  input wire [15:0] CTRL_WORD,
  input wire SUPPLY_24V_OK,
  input wire MAINS_OK,
  input wire FREQ_DETECTED,
  input wire FAN_FAILED,
  input wire [8:0] CH_WARMUP,
  input wire [8:0] CH_FUSE_OK,
  input wire [44:0] CH_CAUSE,
  // outputs watched
  input wire [15:0] MODULE_STATE,
  input wire [15:0] MODULE_ERR_WORD,
  input wire [143:0] CH_STATE,
  input wire [8:0] CH_ENABLE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  AST_READY_ON: assert property (MODULE_STATE[0] |->
    $past(SUPPLY_24V_OK && MAINS_OK && FREQ_DETECTED)) else $error("ready without supply");
  AST_READY_OP: assert property (MODULE_STATE[1] |->
    MODULE_STATE[0] && $past(CTRL_WORD[14])) else $error("operate without master");
  AST_FAN_ERR: assert property (FAN_FAILED |=>
    MODULE_STATE[2] && MODULE_ERR_WORD[3:0] != 4'h0) else $error("fan fault missed");
  AST_ERR_OFF: assert property (MODULE_STATE[2] && $past(MODULE_STATE[2]) |->
    CH_ENABLE == 9'h000) else $error("channel on during module error");
  AST_ERR_CLR: assert property ($fell(MODULE_STATE[2]) |->
    $past(CTRL_WORD[15])) else $error("error cleared without reset bit");
  AST_CH_OFF: assert property (CH_STATE[50] |-> !CH_ENABLE[3])
    else $error("faulty channel still on");
  AST_INACT: assert property (!$past(CTRL_WORD[3]) |->
    CH_STATE[50] == 1'b0 && CH_STATE[60:56] == 5'h00) else $error("inactive channel error");
  AST_CAUSE: assert property ($past(CTRL_WORD[3]) && $past(CH_CAUSE[19:15]) != 5'h00 |->
    CH_STATE[50] && CH_STATE[60:56] != 5'h00) else $error("channel fault missed");
  AST_FUSE: assert property (!$past(RESET) |->
    CH_STATE[3] == $past(CH_FUSE_OK[0])) else $error("fuse bit wrong");
  AST_WARM: assert property (CH_STATE[1] |->
    $past(CTRL_WORD[0]) && $past(CH_WARMUP[0])) else $error("warm-up flag wrong");
  AST_EN_ACT: assert property (CH_ENABLE[0] |-> $past(CTRL_WORD[0]))
    else $error("enable without activation");
endmodule
bind hmc_heater_state hmc_checker u_hmc_checker (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .CTRL_WORD(CTRL_WORD), .SUPPLY_24V_OK(SUPPLY_24V_OK), .MAINS_OK(MAINS_OK),
  .FREQ_DETECTED(FREQ_DETECTED), .FAN_FAILED(FAN_FAILED), .CH_WARMUP(CH_WARMUP),
  .CH_FUSE_OK(CH_FUSE_OK), .CH_CAUSE(CH_CAUSE), .MODULE_STATE(MODULE_STATE),
  .MODULE_ERR_WORD(MODULE_ERR_WORD), .CH_STATE(CH_STATE), .CH_ENABLE(CH_ENABLE));
`default_nettype wire

// ### testbench/hmc_master_model.sv
// Purpose: fieldbus master writing the control word
// Assumes: control changes only at falling edges
// Notes: status is taken every cycle without asking
`timescale 1ns/1ps
`default_nettype none
module hmc_master_model (
  // clock
  input wire clk,
  // status read back
  input wire [15:0] state,
  // control word
  output logic [15:0] ctrl
);
  logic [15:0] seen;
  initial ctrl = 16'h0000;
  always @(posedge clk) seen <= state;
  task put(input [15:0] w);
    @(negedge clk) ctrl = w;
  endtask
  // reset bit held a few cycles since the latch clears late
  task err_reset;
    put(ctrl | 16'h8000);
    repeat (3) @(negedge clk);
    ctrl = ctrl & 16'h7FFF;
  endtask
  task rearm;
    put(ctrl & 16'hBFFF);
    repeat (2) @(negedge clk);
    ctrl = ctrl | 16'h4000;
  endtask
endmodule
`default_nettype wire

// ### testbench/test_hmc_heater_state.sv
// Purpose: self-checking bench of the heater state block
// Assumes: phase tolerance shortened to 20 cycles
// Notes: inputs change at falling edges only
`timescale 1ns/1ps
`default_nettype none
module test_hmc_heater_state;
  logic SYS_CLK, RESET, SUPPLY_24V_OK, MAINS_OK, FREQ_DETECTED, FREQ_OUT_OF_RANGE;
  logic PARAM_INVALID, WATCHDOG_EXPIRED, FAN_FAILED, HEATSINK_OVERTEMP;
  logic [2:0] PHASE_IN_TOL;
  logic [8:0] CH_POWER_OK, CH_WARMUP, CH_FUSE_OK;
  logic [44:0] CH_CAUSE;
  logic [15:0] seed;
  wire [15:0] CTRL_WORD, MODULE_STATE, MODULE_ERR_WORD;
  wire [143:0] CH_STATE;
  wire [8:0] CH_ENABLE;
  integer n_mismatch, samples_checked, i, c, k;
  hmc_heater_state #(.PHASE_TOL_CYCLES(27'd20)) u_hmc_heater_state (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .CTRL_WORD(CTRL_WORD),
    .SUPPLY_24V_OK(SUPPLY_24V_OK), .MAINS_OK(MAINS_OK), .FREQ_DETECTED(FREQ_DETECTED),
    .FREQ_OUT_OF_RANGE(FREQ_OUT_OF_RANGE), .PHASE_IN_TOL(PHASE_IN_TOL),
    .PARAM_INVALID(PARAM_INVALID), .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED),
    .FAN_FAILED(FAN_FAILED), .HEATSINK_OVERTEMP(HEATSINK_OVERTEMP),
    .CH_POWER_OK(CH_POWER_OK), .CH_WARMUP(CH_WARMUP), .CH_FUSE_OK(CH_FUSE_OK),
    .CH_CAUSE(CH_CAUSE), .MODULE_STATE(MODULE_STATE), .MODULE_ERR_WORD(MODULE_ERR_WORD),
    .CH_STATE(CH_STATE), .CH_ENABLE(CH_ENABLE));
  hmc_master_model u_hmc_master_model (.clk(SYS_CLK), .state(MODULE_STATE),
    .ctrl(CTRL_WORD));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [15:0] exp_ch(input integer n);
    exp_ch = {12'h000, CH_FUSE_OK[n], 1'b0, CH_WARMUP[n], CH_POWER_OK[n] | CH_WARMUP[n]};
  endfunction
  function [15:0] exp_fault(input integer n);
    exp_fault = 16'h0000;
    if (CTRL_WORD[n] && CH_CAUSE[5*n+:5] != 5'h00)
      exp_fault = {3'h0, CH_CAUSE[5*n+:5], 8'h04};
  endfunction
  task cyc(input integer n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task set_cause(input integer n, input logic on);
    @(negedge SYS_CLK);
    case (n)
      0: PARAM_INVALID = on;
      1: SUPPLY_24V_OK = !on;
      2: WATCHDOG_EXPIRED = on;
      3: FAN_FAILED = on;
      4: HEATSINK_OVERTEMP = on;
      5: PHASE_IN_TOL = on ? 3'h5 : 3'h7;
      default: FREQ_OUT_OF_RANGE = on;
    endcase
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // over twenty times the expected run length
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    seed = 16'h004D;
    RESET = 1'b1;
    {SUPPLY_24V_OK, MAINS_OK, FREQ_DETECTED} = 3'h7;
    {PARAM_INVALID, WATCHDOG_EXPIRED, FAN_FAILED, HEATSINK_OVERTEMP, FREQ_OUT_OF_RANGE} = 5'h00;
    PHASE_IN_TOL = 3'h7;
    {CH_POWER_OK, CH_WARMUP} = 18'h00000;
    CH_FUSE_OK = 9'h1FF;
    CH_CAUSE = 45'h0;
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK) RESET = 1'b0;
    chk(MODULE_STATE | MODULE_ERR_WORD, 16'h0000);
    chk({7'h00, CH_ENABLE}, 16'h0000);
    cyc(3);
    chk(MODULE_STATE & 16'h0007, 16'h0001);
    MAINS_OK = 1'b0;
    cyc(2);
    chk(MODULE_STATE & 16'h0007, 16'h0000);
    {MAINS_OK, FREQ_DETECTED} = 2'h2;
    cyc(2);
    chk(MODULE_STATE & 16'h0007, 16'h0000);
    FREQ_DETECTED = 1'b1;
    u_hmc_master_model.put(16'h41FF);
    cyc(3);
    chk(MODULE_STATE & 16'h0007, 16'h0003);
    chk({7'h00, CH_ENABLE}, 16'h01FF);
    for (k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      CH_POWER_OK = seed[8:0];
      seed = lfsr(seed);
      CH_WARMUP = seed[8:0];
      CH_FUSE_OK = seed[15:7];
      cyc(2);
      for (c = 0; c < 9; c++)
        chk(CH_STATE[16*c+:16], exp_ch(c));
      chk(u_hmc_master_model.seen, MODULE_STATE);
    end
    // random channel mask with random causes, master kept on
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      u_hmc_master_model.put({7'h20, seed[8:0]});
      seed = lfsr(seed);
      CH_CAUSE = {seed[12:0], seed, seed};
      cyc(2);
      for (c = 0; c < 9; c++)
        chk(CH_STATE[16*c+:16] & 16'h1F04, exp_fault(c));
      u_hmc_master_model.put(16'h4000);
      CH_CAUSE = 45'h0;
      cyc(2);
    end
    u_hmc_master_model.put(16'h41FF);
    cyc(3);
    CH_CAUSE[19:15] = 5'h15;
    cyc(2);
    chk(CH_STATE[63:48] & 16'h1F04, 16'h1504);
    chk({7'h00, CH_ENABLE}, 16'h01F7);
    CH_CAUSE = 45'h0;
    cyc(2);
    chk(CH_STATE[63:48] & 16'h1F04, 16'h1504);
    u_hmc_master_model.put(16'h41F7);
    CH_CAUSE[19:15] = 5'h03;
    cyc(2);
    chk(CH_STATE[63:48] & 16'h1F04, 16'h0000);
    u_hmc_master_model.put(16'h01FF);
    cyc(2);
    CH_CAUSE = 45'h0;
    cyc(2);
    chk(CH_STATE[63:48] & 16'h1F04, 16'h0304);
    u_hmc_master_model.put(16'h01F7);
    cyc(2);
    chk(CH_STATE[63:48] & 16'h0004, 16'h0000);
    u_hmc_master_model.put(16'h41FF);
    cyc(3);
    for (i = 0; i < 7; i++) begin
      set_cause(i, 1'b1);
      cyc(15);
      if (i == 5)
        chk(MODULE_STATE & 16'h0004, 16'h0000);
      cyc(10);
      chk(MODULE_ERR_WORD, 16'(i < 3 ? i + 1 : i + 2));
      chk(MODULE_STATE & 16'h0007, 16'h0004);
      chk({7'h00, CH_ENABLE}, 16'h0000);
      u_hmc_master_model.err_reset;
      cyc(2);
      chk(MODULE_STATE & 16'h0004, 16'h0004);
      set_cause(i, 1'b0);
      u_hmc_master_model.err_reset;
      cyc(2);
      chk(MODULE_STATE & 16'h0005, 16'h0001);
      chk({7'h00, CH_ENABLE}, 16'h0000);
      u_hmc_master_model.rearm;
      cyc(3);
      chk({7'h00, CH_ENABLE}, 16'h01FF);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
